/* File: design/sfsc_pkg.sv */
package sfsc_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_SR_WRITE_NS = 2000;
  localparam int T_PAGE_NS = 2400;
  localparam int T_SECTOR_NS = 8000;
  localparam int T_BLOCK_NS = 12000;
  localparam int T_CHIP_NS = 16000;
  localparam logic [11:0] CY_SR_WRITE =
    12'((T_SR_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] CY_PAGE =
    12'((T_PAGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] CY_SECTOR =
    12'((T_SECTOR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] CY_BLOCK =
    12'((T_BLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] CY_CHIP =
    12'((T_CHIP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================
  // command codes
  localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE_CMD = 8'h04;
  localparam logic [7:0] OP_RDSR_LO = 8'h05;
  localparam logic [7:0] OP_RDSR_HI = 8'h35;
  localparam logic [7:0] OP_STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_QPP = 8'h32;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hD8;
  localparam logic [7:0] OP_CE_A = 8'h60;
  localparam logic [7:0] OP_CE_B = 8'hC7;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_DP = 8'hB9;
  localparam logic [7:0] OP_RELEASE = 8'hAB;
  localparam logic [7:0] OP_PERF = 8'hA3;

  // ==========================================================
  // status bit positions and reset values
  localparam int B_BUSY = 0;
  localparam int B_WEL = 1;
  localparam int B_BP_LSB = 2;
  localparam int B_SRP0 = 7;
  localparam int B_SRP1 = 8;
  localparam int B_QE = 9;
  localparam int B_LB = 10;
  localparam int B_PERF = 13;
  localparam int B_CMP = 14;
  localparam int B_SUS = 15;
  localparam logic [4:0] RST_BP = 5'h00;
  localparam logic [1:0] RST_SRP = 2'h0;
  localparam logic [15:0] RST_STATUS = 16'h0000;

  // ==========================================================
  // array geometry (2 MiB)
  localparam logic [20:0] ADDR_TOP = 21'h1F_FFFF;
  localparam logic [20:0] SZ_64K = 21'h01_0000;
  localparam logic [20:0] SZ_4K = 21'h00_1000;
  localparam logic [20:0] SZ_32K = 21'h00_8000;

  typedef enum logic [1:0] {
    SF_IDLE = 2'b00,
    SF_OPCODE = 2'b01,
    SF_BODY = 2'b10,
    SF_OUT = 2'b11
  } sfsc_state_e;

  // protected-region hit for one byte address
  function automatic logic sfsc_protected(input logic [20:0] a,
                                          input logic [4:0] bp,
                                          input logic cmp);
    logic [20:0] sz;
    logic hit;
    sz = '0;
    hit = 1'b0;
    if (bp[2:1] == 2'b11) begin
      hit = 1'b1;
    end else if (bp[2:0] != 3'h0) begin
      if (!bp[4]) begin
        sz = SZ_64K << 3'(bp[2:0] - 3'h1);
      end else if (bp[2]) begin
        sz = SZ_32K;
      end else begin
        sz = SZ_4K << 3'(bp[1:0] - 2'h1);
      end
      // bp3 picks bottom-up, otherwise top-down
      hit = bp[3] ? (a < sz) : ((ADDR_TOP - a) < sz);
    end
    return hit ^ cmp;
  endfunction : sfsc_protected

endpackage : sfsc_pkg

/* File: design/sfsc_rx_if.sv */
`timescale 1ns/10ps
interface sfsc_rx_if;
  logic frame_start;
  logic frame_end;
  logic bit_aligned;
  logic byte_valid;
  logic [7:0] byte_data;
  logic sclk_fall;

  modport rx (
    output frame_start, frame_end, bit_aligned,
    output byte_valid, byte_data, sclk_fall
  );
  modport core (
    input frame_start, frame_end, bit_aligned,
    input byte_valid, byte_data, sclk_fall
  );
endinterface : sfsc_rx_if

/* File: design/sfsc_serial_rx.sv */
`timescale 1ns/10ps
module sfsc_serial_rx (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_si,
  sfsc_rx_if.rx rx
);

  // ==========================================================
  // synchronisers; stage 3 only feeds edge detection
  logic [2:0] sclk_q;
  logic [2:0] csn_q;
  logic [1:0] si_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic rise;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sclk_q <= 3'h0;
      csn_q <= 3'h7;
      si_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], i_sclk};
      csn_q <= {csn_q[1:0], i_cs_n};
      si_q <= {si_q[0], i_si};
    end
  end

  assign rise = sclk_q[1] && !sclk_q[2] && !csn_q[1];

  // ==========================================================
  // bit assembly, msb first on rising edges
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bit_cnt_q <= 3'h0;
      shift_q <= 7'h00;
      rx.byte_valid <= 1'b0;
      rx.byte_data <= 8'h00;
    end else begin
      rx.byte_valid <= 1'b0;
      if (csn_q[2] && !csn_q[1]) begin
        bit_cnt_q <= 3'h0;
      end else if (rise) begin
        shift_q <= {shift_q[5:0], si_q[1]};
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (bit_cnt_q == 3'h7) begin
          rx.byte_valid <= 1'b1;
          rx.byte_data <= {shift_q, si_q[1]};
        end
      end
    end
  end

  // ==========================================================
  // frame edges
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx.frame_start <= 1'b0;
      rx.frame_end <= 1'b0;
      rx.bit_aligned <= 1'b0;
      rx.sclk_fall <= 1'b0;
    end else begin
      rx.frame_start <= csn_q[2] && !csn_q[1];
      rx.frame_end <= !csn_q[2] && csn_q[1];
      rx.bit_aligned <= (bit_cnt_q == 3'h0);
      rx.sclk_fall <= !sclk_q[1] && sclk_q[2] && !csn_q[1];
    end
  end

endmodule : sfsc_serial_rx

/* File: design/sfsc_op_timer.sv */
`timescale 1ns/10ps
module sfsc_op_timer (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire logic [11:0] i_cycles,
  input wire logic i_pause,
  output logic o_busy,
  output logic o_done
);

  // ==========================================================
  // countdown; pause freezes the count for suspend
  logic [11:0] cnt_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 12'h000;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start && !o_busy) begin
        cnt_q <= i_cycles;
        o_busy <= 1'b1;
      end else if (o_busy && !i_pause) begin
        if (cnt_q <= 12'h001) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 12'h001;
        end
      end
    end
  end

endmodule : sfsc_op_timer

/* File: design/sfsc_flash_status.sv */
`timescale 1ns/10ps
module sfsc_flash_status (
  input wire logic I_CLK_SYS,
  input wire logic I_RESETN,
  input wire logic I_SCLK,
  input wire logic I_CS_N,
  input wire logic I_SI,
  input wire logic I_PROTECT_PIN,
  output logic O_SO,
  output logic O_SO_OE_N,
  output logic O_CTRL_PINS_EN,
  output logic [15:0] O_STATUS
);

  // ==========================================================
  // serial front end and operation timer
  sfsc_rx_if rx ();

  logic sus_q;
  logic tmr_start;
  logic [11:0] tmr_cycles;
  logic tmr_busy;
  logic tmr_done;

  sfsc_serial_rx u_rx (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RESETN),
    .i_sclk(I_SCLK),
    .i_cs_n(I_CS_N),
    .i_si(I_SI),
    .rx(rx.rx)
  );

  sfsc_op_timer u_tmr (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RESETN),
    .i_start(tmr_start),
    .i_cycles(tmr_cycles),
    .i_pause(sus_q),
    .o_busy(tmr_busy),
    .o_done(tmr_done)
  );

  // ==========================================================
  // register fields; reset stands in for a power cycle
  logic wel_q;
  logic [4:0] bp_q;
  logic [1:0] srp_q;
  logic qe_q;
  logic lb_q;
  logic cmp_q;
  logic perf_q;
  logic dpd_q;
  logic arr_op_q;
  logic [15:0] status;

  // ==========================================================
  // frame tracking
  sfsc_pkg::sfsc_state_e st_q;
  logic [2:0] idx_q;
  logic [7:0] opc_q;
  logic [23:0] addr_q;
  logic [7:0] wr_lo_q;
  logic [7:0] wr_hi_q;
  logic [2:0] out_cnt_q;
  logic [1:0] wp_q;

  // ==========================================================
  // commit decode signals
  logic commit;
  logic may_write;
  logic sr_locked;
  logic prot_hit;
  logic wel_set;
  logic wel_clr;
  logic sr_write;
  logic arr_start;
  logic sus_set;
  logic sus_clr;
  logic perf_set;
  logic perf_clr;
  logic dpd_set;
  logic [7:0] out_byte;

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      wp_q <= 2'h0;
    end else begin
      wp_q <= {wp_q[0], I_PROTECT_PIN};
    end
  end

  // reserved S12/S11 tie to zero
  always_comb begin
    status = sfsc_pkg::RST_STATUS;
    status[sfsc_pkg::B_BUSY] = tmr_busy && !sus_q;
    status[sfsc_pkg::B_WEL] = wel_q;
    status[sfsc_pkg::B_BP_LSB +: 5] = bp_q;
    status[sfsc_pkg::B_SRP0] = srp_q[0];
    status[sfsc_pkg::B_SRP1] = srp_q[1];
    status[sfsc_pkg::B_QE] = qe_q;
    status[sfsc_pkg::B_LB] = lb_q;
    status[sfsc_pkg::B_PERF] = perf_q;
    status[sfsc_pkg::B_CMP] = cmp_q;
    status[sfsc_pkg::B_SUS] = sus_q;
  end

  // ==========================================================
  // command framing
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      st_q <= sfsc_pkg::SF_IDLE;
    end else if (rx.frame_start) begin
      st_q <= sfsc_pkg::SF_OPCODE;
    end else if (rx.frame_end) begin
      st_q <= sfsc_pkg::SF_IDLE;
    end else if (rx.byte_valid) begin
      unique case (st_q)
        sfsc_pkg::SF_OPCODE: begin
          // deep power-down only answers the release code
          if (dpd_q && rx.byte_data != sfsc_pkg::OP_RELEASE) begin
            st_q <= sfsc_pkg::SF_IDLE;
          end else if (rx.byte_data == sfsc_pkg::OP_RDSR_LO ||
                       rx.byte_data == sfsc_pkg::OP_RDSR_HI) begin
            st_q <= sfsc_pkg::SF_OUT;
          end else begin
            st_q <= sfsc_pkg::SF_BODY;
          end
        end
        sfsc_pkg::SF_IDLE,
        sfsc_pkg::SF_BODY,
        sfsc_pkg::SF_OUT: begin
          st_q <= st_q;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      idx_q <= 3'h0;
      opc_q <= 8'h00;
      addr_q <= 24'h00_0000;
      wr_lo_q <= 8'h00;
      wr_hi_q <= 8'h00;
    end else if (rx.frame_start) begin
      idx_q <= 3'h0;
    end else if (rx.byte_valid) begin
      if (idx_q != 3'h7) begin
        idx_q <= idx_q + 3'h1;
      end
      if (idx_q == 3'h0) begin
        opc_q <= rx.byte_data;
      end
      if (idx_q >= 3'h1 && idx_q <= 3'h3) begin
        addr_q <= {addr_q[15:0], rx.byte_data};
      end
      if (idx_q == 3'h1) begin
        wr_lo_q <= rx.byte_data;
      end
      if (idx_q == 3'h2) begin
        wr_hi_q <= rx.byte_data;
      end
    end
  end

  // ==========================================================
  // command execution at select rising
  always_comb begin
    commit = rx.frame_end && st_q == sfsc_pkg::SF_BODY;
    may_write = wel_q && !tmr_busy && rx.bit_aligned;
    // pin only counts while it is a control pin
    sr_locked = srp_q[1] ||
                (srp_q == 2'b01 && !qe_q && !wp_q[1]);
    prot_hit = sfsc_pkg::sfsc_protected(addr_q[20:0], bp_q, cmp_q);
    wel_set = 1'b0;
    wel_clr = 1'b0;
    sr_write = 1'b0;
    arr_start = 1'b0;
    tmr_cycles = sfsc_pkg::CY_PAGE;
    sus_set = 1'b0;
    sus_clr = 1'b0;
    perf_set = 1'b0;
    perf_clr = 1'b0;
    dpd_set = 1'b0;
    if (commit) begin
      unique case (opc_q)
        sfsc_pkg::OP_WRITE_ENABLE_CMD: begin
          wel_set = rx.bit_aligned && !tmr_busy;
        end
        sfsc_pkg::OP_WRITE_DISABLE_CMD: begin
          wel_clr = rx.bit_aligned && !tmr_busy;
        end
        sfsc_pkg::OP_STATUS_WRITE_CMD: begin
          sr_write = may_write && !sr_locked && idx_q >= 3'h2;
          tmr_cycles = sfsc_pkg::CY_SR_WRITE;
        end
        sfsc_pkg::OP_PP,
        sfsc_pkg::OP_QPP: begin
          // partial byte fails alignment; latch untouched
          arr_start = may_write && idx_q >= 3'h5 && !prot_hit &&
                      (opc_q != sfsc_pkg::OP_QPP || qe_q);
        end
        sfsc_pkg::OP_SE: begin
          arr_start = may_write && idx_q == 3'h4 && !prot_hit;
          tmr_cycles = sfsc_pkg::CY_SECTOR;
        end
        sfsc_pkg::OP_BE32,
        sfsc_pkg::OP_BE64: begin
          arr_start = may_write && idx_q == 3'h4 && !prot_hit;
          tmr_cycles = sfsc_pkg::CY_BLOCK;
        end
        sfsc_pkg::OP_CE_A,
        sfsc_pkg::OP_CE_B: begin
          arr_start = may_write && idx_q == 3'h1 &&
                      bp_q[2:0] == 3'h0 && !cmp_q;
          tmr_cycles = sfsc_pkg::CY_CHIP;
        end
        sfsc_pkg::OP_SUSPEND: begin
          sus_set = tmr_busy && arr_op_q && !sus_q;
        end
        sfsc_pkg::OP_RESUME: begin
          sus_clr = sus_q;
        end
        sfsc_pkg::OP_PERF: begin
          perf_set = idx_q == 3'h4 && !tmr_busy;
        end
        sfsc_pkg::OP_RELEASE: begin
          perf_clr = 1'b1;
        end
        sfsc_pkg::OP_DP: begin
          dpd_set = rx.bit_aligned && !tmr_busy;
        end
        default: begin
          wel_set = 1'b0;
        end
      endcase
    end
    tmr_start = sr_write || arr_start;
  end

  // ==========================================================
  // write latch: a set in the clear cycle wins
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      wel_q <= 1'b0;
    end else if (wel_set) begin
      wel_q <= 1'b1;
    end else if (wel_clr || tmr_done) begin
      wel_q <= 1'b0;
    end
  end

  // status fields change at write start, busy covers the program time
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      bp_q <= sfsc_pkg::RST_BP;
      srp_q <= sfsc_pkg::RST_SRP;
      qe_q <= 1'b0;
      lb_q <= 1'b0;
      cmp_q <= 1'b0;
    end else if (sr_write) begin
      bp_q <= wr_lo_q[sfsc_pkg::B_BP_LSB +: 5];
      srp_q[0] <= wr_lo_q[sfsc_pkg::B_SRP0];
      if (idx_q >= 3'h3) begin
        srp_q[1] <= wr_hi_q[sfsc_pkg::B_SRP1 - 8];
        qe_q <= wr_hi_q[sfsc_pkg::B_QE - 8];
        lb_q <= lb_q | wr_hi_q[sfsc_pkg::B_LB - 8];
        cmp_q <= wr_hi_q[sfsc_pkg::B_CMP - 8];
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      arr_op_q <= 1'b0;
    end else if (arr_start) begin
      arr_op_q <= 1'b1;
    end else if (tmr_done || sr_write) begin
      arr_op_q <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      sus_q <= 1'b0;
    end else if (sus_set) begin
      sus_q <= 1'b1;
    end else if (sus_clr) begin
      sus_q <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      perf_q <= 1'b0;
      dpd_q <= 1'b0;
    end else begin
      if (perf_set) begin
        perf_q <= 1'b1;
      end else if (perf_clr) begin
        perf_q <= 1'b0;
      end
      if (dpd_set) begin
        dpd_q <= 1'b1;
      end else if (perf_clr) begin
        dpd_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // serial out: live status, so busy can be polled continuously
  assign out_byte = (opc_q == sfsc_pkg::OP_RDSR_LO) ? status[7:0]
                                                   : status[15:8];

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_SO <= 1'b0;
      out_cnt_q <= 3'h0;
    end else if (rx.frame_start) begin
      out_cnt_q <= 3'h0;
    end else if (rx.sclk_fall && st_q == sfsc_pkg::SF_OUT) begin
      O_SO <= out_byte[3'h7 - out_cnt_q];
      out_cnt_q <= out_cnt_q + 3'h1;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      O_SO_OE_N <= 1'b1;
      O_CTRL_PINS_EN <= 1'b1;
      O_STATUS <= sfsc_pkg::RST_STATUS;
    end else begin
      O_SO_OE_N <= !(st_q == sfsc_pkg::SF_OUT) || rx.frame_end;
      O_CTRL_PINS_EN <= !qe_q;
      O_STATUS <= status;
    end
  end

endmodule : sfsc_flash_status

/* File: sim/sfsc_flash_status_chk.sv */
`timescale 1ns/10ps
module sfsc_flash_status_chk (
  input wire logic I_CLK_SYS,
  input wire logic I_RESETN,
  input wire logic I_SCLK,
  input wire logic I_CS_N,
  input wire logic I_SI,
  input wire logic I_PROTECT_PIN,
  input wire logic O_SO,
  input wire logic O_SO_OE_N,
  input wire logic O_CTRL_PINS_EN,
  input wire logic [15:0] O_STATUS
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESETN);

  // ==========================================================
  // cycles since select was last seen high
  logic [3:0] since_hi_q;
  always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
    if (!I_RESETN) begin
      since_hi_q <= 4'h0;
    end else if (I_CS_N) begin
      since_hi_q <= 4'h0;
    end else if (since_hi_q != 4'hF) begin
      since_hi_q <= since_hi_q + 4'h1;
    end
  end

  // ==========================================================
  // properties
  sequence s_pin_locked;
    (!I_PROTECT_PIN && O_STATUS[8:7] == 2'b01 && !O_STATUS[9])[*8];
  endsequence
  sequence s_ctrl_settled;
    ($stable(O_STATUS[9]) && $stable(O_CTRL_PINS_EN))[*3];
  endsequence
  property p_resv; O_STATUS[12:11] == 2'b00; endproperty
  property p_busy_latch; O_STATUS[0] |-> O_STATUS[1]; endproperty
  property p_done;
    $fell(O_STATUS[0]) |-> ##[0:1] (!O_STATUS[1] || O_STATUS[15]);
  endproperty
  property p_latch_rise; $rose(O_STATUS[1]) |-> since_hi_q < 4'hA; endproperty
  property p_bp_commit; $changed(O_STATUS[6:2]) |-> since_hi_q < 4'hA; endproperty
  property p_srp_lock;
    $past(O_STATUS[8]) |-> $stable(O_STATUS[10:2]) && $stable(O_STATUS[14]);
  endproperty
  property p_pin_lock; s_pin_locked |=> $stable(O_STATUS[10:2]); endproperty
  property p_otp; $past(O_STATUS[10]) |-> O_STATUS[10]; endproperty
  property p_ctrl; s_ctrl_settled |-> O_CTRL_PINS_EN != O_STATUS[9]; endproperty
  property p_oe_idle; I_CS_N [*8] |-> O_SO_OE_N; endproperty
  property p_paused; O_STATUS[15] |-> !O_STATUS[0]; endproperty

  a_resv: assert property (p_resv) else $error("reserved bits set");
  a_busy_latch: assert property (p_busy_latch)
    else $error("busy without latch");
  a_done: assert property (p_done) else $error("latch kept at end");
  a_latch_rise: assert property (p_latch_rise)
    else $error("latch set mid frame");
  a_bp_commit: assert property (p_bp_commit)
    else $error("protect field changed mid frame");
  a_srp_lock: assert property (p_srp_lock)
    else $error("locked register changed");
  a_pin_lock: assert property (p_pin_lock)
    else $error("pin lock ignored");
  a_otp: assert property (p_otp) else $error("lock bit cleared");
  a_ctrl: assert property (p_ctrl) else $error("ctrl pins wrong");
  a_oe_idle: assert property (p_oe_idle)
    else $error("output driven while deselected");
  a_paused: assert property (p_paused) else $error("busy while paused");
endmodule : sfsc_flash_status_chk

/* File: sim/sfsc_host_model.sv */
`timescale 1ns/10ps
module sfsc_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_si,
  input wire logic i_so,
  input wire logic i_so_oe_n
);
  // half period kept above the device's minimum sampling span
  localparam int HALF_NS = 48;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end

  // ==========================================================
  // one bit: data set while clock low, both sides take on rise
  task automatic tick(input logic v, inout logic [7:0] r);
    o_si = v;
    #(HALF_NS) o_sclk = 1'b1;
    // released output line shows the inverse, so a late enable is seen
    r = {r[6:0], i_so_oe_n ? ~i_so : i_so};
    #(HALF_NS) o_sclk = 1'b0;
  endtask : tick

  // ==========================================================
  // opcode first, then nby-1 bytes, xb loose bits, nr bytes read
  task automatic xfer(input logic [31:0] w, input int nby, input int xb,
                      input int nr, output logic [7:0] r);
    logic [31:0] sh;
    sh = w;
    r = 8'h00;
    #1.3 o_cs_n = 1'b0;
    #(HALF_NS);
    repeat (nby * 8) begin
      tick(sh[31], r);
      sh = sh << 1;
    end
    repeat (xb + nr * 8) tick(~o_si, r);
    #(HALF_NS) o_cs_n = 1'b1;
    // released data line must not keep its last value
    o_si = ~o_si;
    #200;
  endtask : xfer
endmodule : sfsc_host_model

/* File: sim/test_serial_flash_status_and_framing.sv */
`timescale 1ns/10ps
module test_serial_flash_status_and_framing;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic prot_pin = 1'b1;
  logic sclk, cs_n, si, so, so_oe_n, ctrl_en;
  logic [15:0] status;
  logic [7:0] exp_q[$];
  logic [7:0] seen_q[$];
  string nm_q[$];
  int n_mismatch = 0;
  int total_checks = 0;
  logic [4:0] rnd;
  localparam logic [7:0] LO = sfsc_pkg::OP_RDSR_LO;
  localparam logic [7:0] HI = sfsc_pkg::OP_RDSR_HI;

  always #2 clk = ~clk;

  sfsc_flash_status i_sfsc_flash_status (.I_CLK_SYS(clk), .I_RESETN(rst_n),
    .I_SCLK(sclk), .I_CS_N(cs_n), .I_SI(si), .I_PROTECT_PIN(prot_pin),
    .O_SO(so), .O_SO_OE_N(so_oe_n), .O_CTRL_PINS_EN(ctrl_en),
    .O_STATUS(status));
  sfsc_host_model i_sfsc_host_model (.o_sclk(sclk), .o_cs_n(cs_n),
    .o_si(si), .i_so(so), .i_so_oe_n(so_oe_n));

  // ==========================================================
  // compare oldest note with each result
  always @(negedge clk) begin
    while (seen_q.size() > 0) begin
      total_checks++;
      if (exp_q[0] !== seen_q[0]) begin
        n_mismatch++;
        $display("unexpected %s: expected %h seen %h", nm_q[0], exp_q[0],
                 seen_q[0]);
      end
      exp_q.delete(0);
      seen_q.delete(0);
      nm_q.delete(0);
    end
  end

  // ==========================================================
  // tasks
  task automatic note(input string nm, input logic [7:0] e,
                      input logic [7:0] s);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    seen_q.push_back(s);
  endtask : note
  task automatic xf(input logic [31:0] w, input int nby, input int xb = 0);
    logic [7:0] r;
    i_sfsc_host_model.xfer(w, nby, xb, 0, r);
  endtask : xf
  task automatic chk(input string nm, input logic [7:0] op,
                     input logic [7:0] e, input int nr = 1);
    logic [7:0] r;
    i_sfsc_host_model.xfer({op, 24'h00_0000}, 1, 0, nr, r);
    note(nm, e, r);
  endtask : chk
  task automatic idle;
    logic [7:0] r;
    r = 8'hFF;
    // bounded poll, a stuck operation shows as a mismatch
    for (int i = 0; i < 30 && r[0] !== 1'b0; i++) begin
      i_sfsc_host_model.xfer({LO, 24'h00_0000}, 1, 0, 1, r);
    end
    note("busy", 8'h00, {7'h00, r[0]});
  endtask : idle
  task automatic latch_on;
    xf({sfsc_pkg::OP_WRITE_ENABLE_CMD, 24'h00_0000}, 1);
  endtask : latch_on
  task automatic latch_off;
    xf({sfsc_pkg::OP_WRITE_DISABLE_CMD, 24'h00_0000}, 1);
  endtask : latch_off
  task automatic status_write_cmd(input logic [7:0] l, input logic [7:0] h);
    latch_on();
    xf({sfsc_pkg::OP_STATUS_WRITE_CMD, l, h, 8'h00}, 3);
    idle();
  endtask : status_write_cmd
  task automatic pwr;
    @(posedge clk) rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : pwr
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // tests
  initial begin
    rnd = 5'($urandom(12));
    pwr();
    chk("status low", LO, 8'h00);
    chk("status high", HI, 8'h00);
    note("ctrl pins", 8'h01, {7'h00, ctrl_en});
    xf({sfsc_pkg::OP_STATUS_WRITE_CMD, 8'h1C, 16'h0000}, 2);
    chk("unlatched write", LO, 8'h00);
    xf({sfsc_pkg::OP_WRITE_ENABLE_CMD, 24'h00_0000}, 1, 1);
    chk("nine clocks", LO, 8'h00);
    latch_on();
    chk("stream", LO, 8'h02, 2);
    xf({sfsc_pkg::OP_PP, 24'h00_0000}, 4, 12);
    chk("half byte", LO, 8'h02);
    xf({sfsc_pkg::OP_QPP, 24'h00_0000}, 4, 8);
    chk("quad refused", LO, 8'h02);
    latch_off();
    chk("latch off", LO, 8'h00);
    xf({sfsc_pkg::OP_DP, 24'h00_0000}, 1);
    latch_on();
    xf({sfsc_pkg::OP_RELEASE, 24'h00_0000}, 1);
    chk("power down", LO, 8'h00);
    $display("test framing done");
    rnd = 5'($urandom());
    latch_on();
    // pin is driven, never tied, while lanes are enabled
    xf({sfsc_pkg::OP_STATUS_WRITE_CMD, 1'b0, rnd, 2'b00, 8'h1A, 8'h00}, 3);
    chk("write busy", LO, {1'b0, rnd, 2'b11});
    idle();
    chk("written low", LO, {1'b0, rnd, 2'b00});
    chk("written high", HI, 8'h02);
    note("ctrl pins", 8'h00, {7'h00, ctrl_en});
    status_write_cmd(8'h00, 8'h00);
    latch_on();
    xf({sfsc_pkg::OP_SE, 24'h00_0000}, 4);
    chk("erase busy", LO, 8'h03);
    xf({sfsc_pkg::OP_SUSPEND, 24'h00_0000}, 1);
    chk("paused", HI, 8'h80);
    chk("paused low", LO, 8'h02);
    xf({sfsc_pkg::OP_RESUME, 24'h00_0000}, 1);
    chk("resumed", HI, 8'h00);
    idle();
    chk("erase done", LO, 8'h00);
    $display("test write and erase done");
    // top 64 KiB guarded
    status_write_cmd(8'h04, 8'h00);
    latch_on();
    xf({sfsc_pkg::OP_SE, 24'h1F_0000}, 4);
    chk("guarded erase", LO, 8'h06);
    for (int i = 0; i < 2; i++) begin
      xf({i ? sfsc_pkg::OP_CE_B : sfsc_pkg::OP_CE_A, 24'h00_0000}, 1);
      chk("chip erase", LO, 8'h06);
    end
    xf({sfsc_pkg::OP_SE, 24'h00_0000}, 4);
    chk("open erase", LO, 8'h07);
    idle();
    status_write_cmd(8'h00, 8'h40);
    latch_on();
    xf({sfsc_pkg::OP_BE64, 24'h00_0000}, 4);
    chk("complement", LO, 8'h02);
    status_write_cmd(8'h00, 8'h00);
    xf({sfsc_pkg::OP_PERF, 24'h00_0000}, 4);
    chk("perf on", HI, 8'h20);
    xf({sfsc_pkg::OP_RELEASE, 24'h00_0000}, 1);
    chk("perf off", HI, 8'h00);
    status_write_cmd(8'h00, 8'h04);
    status_write_cmd(8'h00, 8'h00);
    chk("lock bit", HI, 8'h04);
    $display("test protection done");
    for (int c = 0; c < 4; c++) begin
      pwr();
      chk("after cycle", HI, 8'h00);
      @(posedge clk) prot_pin <= 1'b0;
      status_write_cmd({c[0], 7'h00}, {7'h00, c[1]});
      rnd = 5'($urandom()) | 5'h01;
      status_write_cmd({c[0], rnd, 2'b00}, {7'h00, c[1]});
      latch_off();
      chk("guarded low", LO,
          (c == 0) ? {1'b0, rnd, 2'b00} : {c[0], 7'h00});
      if (c == 1) begin
        @(posedge clk) prot_pin <= 1'b1;
        status_write_cmd({1'b1, rnd, 2'b00}, 8'h00);
        chk("pin high", LO, {1'b1, rnd, 2'b00});
      end
    end
    $display("test register lock done");
    repeat (4) @(posedge clk);
    tally_and_finish();
  end

  initial begin
    #400_000;
    n_mismatch++;
    $display("unexpected run time: expected end seen timeout");
    tally_and_finish();
  end
endmodule : test_serial_flash_status_and_framing

bind sfsc_flash_status sfsc_flash_status_chk i_sfsc_flash_status_chk (
  .I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN), .I_SCLK(I_SCLK),
  .I_CS_N(I_CS_N), .I_SI(I_SI), .I_PROTECT_PIN(I_PROTECT_PIN),
  .O_SO(O_SO), .O_SO_OE_N(O_SO_OE_N), .O_CTRL_PINS_EN(O_CTRL_PINS_EN),
  .O_STATUS(O_STATUS));
